// >>> logic/ushfc_pkg.sv
// Constants for the channel status, divisor and flow-control register block
package ushfc_pkg;
	// Register map
	localparam logic [3:0] ADDR_HOLDING = 4'h0;
	localparam logic [3:0] ADDR_LINE_STATUS = 4'h1;
	localparam logic [3:0] ADDR_MODEM_STATUS = 4'h2;
	localparam logic [3:0] ADDR_SCRATCH = 4'h3;
	localparam logic [3:0] ADDR_DIV_LOW = 4'h4;
	localparam logic [3:0] ADDR_DIV_HIGH = 4'h5;
	localparam logic [3:0] ADDR_FRACTION = 4'h6;
	localparam logic [3:0] ADDR_ENHANCED = 4'h7;
	localparam logic [3:0] ADDR_MODEM_CTRL = 4'h8;
	localparam logic [3:0] ADDR_INT_ENABLES = 4'h9;
	localparam logic [3:0] ADDR_FIFO_CTRL = 4'hA;
	localparam logic [3:0] ADDR_RESUME1 = 4'hB;
	localparam logic [3:0] ADDR_RESUME2 = 4'hC;
	localparam logic [3:0] ADDR_PAUSE1 = 4'hD;
	localparam logic [3:0] ADDR_PAUSE2 = 4'hE;
	// Field positions
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_OUT1 = 2;
	localparam int MC_OUT2 = 3;
	localparam int MC_LOOP = 4;
	localparam int IE_LINE = 2;
	localparam int IE_MODEM = 3;
	localparam int EF_ENH = 4;
	localparam int EF_ACTS = 7;
	localparam int FC_FIFO = 0;
	localparam int TAG_PE = 8;
	localparam int TAG_FE = 9;
	localparam int TAG_BI = 10;
	// Reset values
	localparam logic [7:0] RST_SCRATCH = 8'hFF;
	localparam logic [7:0] RST_DIV_LOW = 8'h01;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// Sampling rate codes
	localparam logic [1:0] SAMP_16X = 2'h0;
	localparam logic [1:0] SAMP_8X = 2'h1;
	localparam logic [1:0] SAMP_4X = 2'h2;
endpackage

// >>> logic/ushfc_regs.sv
// Status, divisor and flow-control register block of one serial channel
`timescale 1ns/10ps
module ushfc_regs #(
	parameter int DEPTH = 64
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [7:0] rdata_o,
	// Receiver character events
	input wire logic rx_done_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_parity_err_i,
	input wire logic rx_frame_err_i,
	input wire logic rx_break_i,
	// Serial and modem pins, active low where named
	input wire logic rx_line_i,
	input wire logic cts_n_i,
	input wire logic dsr_n_i,
	input wire logic ring_in_n_i,
	input wire logic carrier_in_n_i,
	// Transmit shifter handshake
	input wire logic tx_ready_i,
	input wire logic tx_busy_i,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	// Interrupt requests
	output logic line_irq_o,
	output logic modem_irq_o,
	// Baud configuration
	output logic [15:0] baud_divisor_o,
	output logic [3:0] baud_fraction_o,
	output logic [1:0] sample_rate_o,
	// Modem control and flow control
	output logic [7:0] modem_control_o,
	output logic [15:0] tx_resume_code_o,
	output logic [15:0] tx_pause_code_o,
	output logic [1:0] tx_code_len_o,
	output logic resume_seen_o,
	output logic pause_seen_o
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][10:0] rx_mem;
		logic [PW-1:0] rx_wp;
		logic [PW-1:0] rx_rp;
		logic [CW-1:0] rx_cnt;
		logic [CW-1:0] err_cnt;
		logic [DEPTH-1:0][7:0] tx_mem;
		logic [PW-1:0] tx_wp;
		logic [PW-1:0] tx_rp;
		logic [CW-1:0] tx_cnt;
		logic overrun;
		logic brk_hold;
		logic rx_s1;
		logic rx_s2;
		logic [3:0] pin_s1;
		logic [3:0] pin_s2;
		logic [3:0] ms_prev;
		logic [3:0] delta;
		logic [7:0] scratch;
		logic [7:0] dll;
		logic [7:0] divisor_high_byte;
		logic [7:0] frac;
		logic [7:0] enhanced_features;
		logic [7:0] modem_control;
		logic [7:0] interrupt_enables;
		logic [7:0] fctl;
		logic [7:0] res1;
		logic [7:0] res2;
		logic [7:0] pau1;
		logic [7:0] pau2;
		logic prev_res1;
		logic prev_pau1;
		logic [7:0] rdata;
		logic tx_valid;
		logic [7:0] tx_data;
		logic line_irq;
		logic modem_irq;
		logic [1:0] samp;
		logic [15:0] res_code;
		logic [15:0] pau_code;
		logic [1:0] code_len;
		logic res_seen;
		logic pau_seen;
	} ushfc_state_t;

	ushfc_state_t s;
	ushfc_state_t next_s;

	logic [3:0] ms_now;
	logic [7:0] ls;
	logic [10:0] rx_head;
	logic rx_full;
	logic tx_full;
	logic push;
	logic pop;
	logic tx_take;
	logic tx_push;
	logic enh;
	logic sel_first;
	logic sel_second;
	logic sel_either;
	logic sel_seq;
	logic head_err;
	logic in_err;

	always_comb begin
		next_s = s;
		next_s.res_seen = 1'b0;
		next_s.pau_seen = 1'b0;
		enh = s.enhanced_features[ushfc_pkg::EF_ENH];
		rx_head = s.rx_mem[s.rx_rp];

		// Pin synchronisers; first stage feeds only the second
		next_s.rx_s1 = rx_line_i;
		next_s.rx_s2 = s.rx_s1;
		next_s.pin_s1 = {carrier_in_n_i, ring_in_n_i, dsr_n_i, cts_n_i};
		next_s.pin_s2 = s.pin_s1;

		// Upper modem bits: pins inverted or looped control bits
		if (s.modem_control[ushfc_pkg::MC_LOOP]) begin
			ms_now = {s.modem_control[ushfc_pkg::MC_OUT2], s.modem_control[ushfc_pkg::MC_OUT1],
				s.modem_control[ushfc_pkg::MC_DTR], s.modem_control[ushfc_pkg::MC_RTS]};
		end else begin
			ms_now = ~s.pin_s2;
		end

		// Storage in non-FIFO mode holds a single entry
		if (s.fctl[ushfc_pkg::FC_FIFO]) begin
			rx_full = s.rx_cnt == CW'(DEPTH);
			tx_full = s.tx_cnt == CW'(DEPTH);
		end else begin
			rx_full = s.rx_cnt != '0;
			tx_full = s.tx_cnt != '0;
		end

		head_err = (s.rx_cnt != '0) && (rx_head[ushfc_pkg::TAG_PE] ||
			rx_head[ushfc_pkg::TAG_FE] || rx_head[ushfc_pkg::TAG_BI]);
		in_err = rx_parity_err_i || rx_frame_err_i || rx_break_i;

		// Line status word built from live state
		ls[0] = s.rx_cnt != '0;
		ls[1] = s.overrun;
		ls[2] = ls[0] && rx_head[ushfc_pkg::TAG_PE];
		ls[3] = ls[0] && rx_head[ushfc_pkg::TAG_FE];
		ls[4] = (ls[0] && rx_head[ushfc_pkg::TAG_BI]) || s.brk_hold;
		ls[5] = s.tx_cnt == '0;
		ls[6] = (s.tx_cnt == '0) && !tx_busy_i;
		ls[7] = s.err_cnt != '0;

		// Break line released: allow the next break character
		if (s.rx_s2) begin
			next_s.brk_hold = 1'b0;
		end

		// Receive push; a repeat break while line stays low is not stored
		push = 1'b0;
		if (rx_done_i && !(rx_break_i && s.brk_hold)) begin
			if (rx_break_i) begin
				next_s.brk_hold = 1'b1;
			end
			if (rx_full) begin
				push = 1'b0;
			end else begin
				push = 1'b1;
			end
		end
		pop = re_i && (addr_i == ushfc_pkg::ADDR_HOLDING) && (s.rx_cnt != '0);
		if (push) begin
			next_s.rx_mem[s.rx_wp] = {rx_break_i, rx_frame_err_i,
				rx_parity_err_i, rx_data_i};
			next_s.rx_wp = PW'(s.rx_wp + 1'b1);
		end
		if (pop) begin
			next_s.rx_rp = PW'(s.rx_rp + 1'b1);
		end
		next_s.rx_cnt = CW'(s.rx_cnt + CW'(push) - CW'(pop));
		// Error count tracks tagged entries in storage
		next_s.err_cnt = CW'(s.err_cnt + CW'(push && in_err)
			- CW'(pop && head_err));

		// Overrun: cleared by a status read, a new overrun wins
		if (re_i && addr_i == ushfc_pkg::ADDR_LINE_STATUS) begin
			next_s.overrun = 1'b0;
		end
		if (rx_done_i && rx_full && !(rx_break_i && s.brk_hold)) begin
			next_s.overrun = 1'b1;
		end

		// Modem change flags; read clears, a fresh change wins
		next_s.ms_prev = ms_now;
		if (re_i && addr_i == ushfc_pkg::ADDR_MODEM_STATUS) begin
			next_s.delta = 4'h0;
		end
		if (ms_now[0] != s.ms_prev[0]) begin
			next_s.delta[0] = 1'b1;
		end
		if (ms_now[1] != s.ms_prev[1]) begin
			next_s.delta[1] = 1'b1;
		end
		// Ring pin going high means its status bit falls
		if (!ms_now[2] && s.ms_prev[2]) begin
			next_s.delta[2] = 1'b1;
		end
		if (ms_now[3] != s.ms_prev[3]) begin
			next_s.delta[3] = 1'b1;
		end

		// Transmit storage; host write is dropped when full
		tx_take = s.tx_valid && tx_ready_i;
		tx_push = we_i && (addr_i == ushfc_pkg::ADDR_HOLDING) && !tx_full;
		if (tx_push) begin
			next_s.tx_mem[s.tx_wp] = wdata_i;
			next_s.tx_wp = PW'(s.tx_wp + 1'b1);
		end
		if (tx_take) begin
			next_s.tx_rp = PW'(s.tx_rp + 1'b1);
		end
		next_s.tx_cnt = CW'(s.tx_cnt + CW'(tx_push) - CW'(tx_take));

		// Register writes; enhanced fields only with enhanced enable
		if (we_i) begin
			unique case (addr_i)
				ushfc_pkg::ADDR_SCRATCH: next_s.scratch = wdata_i;
				ushfc_pkg::ADDR_DIV_LOW: next_s.dll = wdata_i;
				ushfc_pkg::ADDR_DIV_HIGH: next_s.divisor_high_byte = wdata_i;
				ushfc_pkg::ADDR_FRACTION: begin
					if (enh) begin
						next_s.frac = wdata_i;
					end
				end
				ushfc_pkg::ADDR_ENHANCED: next_s.enhanced_features = wdata_i;
				ushfc_pkg::ADDR_MODEM_CTRL: begin
					next_s.modem_control[4:0] = wdata_i[4:0];
					if (enh) begin
						next_s.modem_control[7:5] = wdata_i[7:5];
					end
				end
				ushfc_pkg::ADDR_INT_ENABLES: begin
					next_s.interrupt_enables[3:0] = wdata_i[3:0];
					if (enh) begin
						next_s.interrupt_enables[7:4] = wdata_i[7:4];
					end
				end
				ushfc_pkg::ADDR_FIFO_CTRL: next_s.fctl = wdata_i;
				ushfc_pkg::ADDR_RESUME1: next_s.res1 = wdata_i;
				ushfc_pkg::ADDR_RESUME2: next_s.res2 = wdata_i;
				ushfc_pkg::ADDR_PAUSE1: next_s.pau1 = wdata_i;
				ushfc_pkg::ADDR_PAUSE2: next_s.pau2 = wdata_i;
				default: begin
				end
			endcase
		end

		// Read data, valid the cycle after the strobe only
		next_s.rdata = 8'h00;
		if (re_i) begin
			unique case (addr_i)
				ushfc_pkg::ADDR_HOLDING: next_s.rdata = rx_head[7:0];
				ushfc_pkg::ADDR_LINE_STATUS: next_s.rdata = ls;
				ushfc_pkg::ADDR_MODEM_STATUS: next_s.rdata = {ms_now, s.delta};
				ushfc_pkg::ADDR_SCRATCH: next_s.rdata = s.scratch;
				ushfc_pkg::ADDR_DIV_LOW: next_s.rdata = s.dll;
				ushfc_pkg::ADDR_DIV_HIGH: next_s.rdata = s.divisor_high_byte;
				ushfc_pkg::ADDR_FRACTION: begin
					if (enh) begin
						next_s.rdata = {2'h0, s.frac[5:0]};
					end
				end
				ushfc_pkg::ADDR_ENHANCED: next_s.rdata = s.enhanced_features;
				ushfc_pkg::ADDR_MODEM_CTRL: next_s.rdata = s.modem_control;
				ushfc_pkg::ADDR_INT_ENABLES: next_s.rdata = s.interrupt_enables;
				ushfc_pkg::ADDR_FIFO_CTRL: next_s.rdata = s.fctl;
				ushfc_pkg::ADDR_RESUME1: next_s.rdata = s.res1;
				ushfc_pkg::ADDR_RESUME2: next_s.rdata = s.res2;
				ushfc_pkg::ADDR_PAUSE1: next_s.rdata = s.pau1;
				ushfc_pkg::ADDR_PAUSE2: next_s.rdata = s.pau2;
				default: next_s.rdata = 8'h00;
			endcase
		end

		// Receive flow matching; selection assumed cleared between changes
		sel_first = s.enhanced_features[1:0] == 2'b10;
		sel_second = s.enhanced_features[1:0] == 2'b01;
		sel_either = (s.enhanced_features[1:0] == 2'b11) &&
			(s.enhanced_features[3:2] == 2'b10 || s.enhanced_features[3:2] == 2'b01);
		sel_seq = (s.enhanced_features[1:0] == 2'b11) && !sel_either;
		if (rx_done_i && !rx_break_i) begin
			next_s.prev_res1 = rx_data_i == s.res1;
			next_s.prev_pau1 = rx_data_i == s.pau1;
			next_s.res_seen = (sel_first && rx_data_i == s.res1) ||
				(sel_second && rx_data_i == s.res2) ||
				(sel_either && (rx_data_i == s.res1 || rx_data_i == s.res2)) ||
				(sel_seq && s.prev_res1 && rx_data_i == s.res2);
			next_s.pau_seen = (sel_first && rx_data_i == s.pau1) ||
				(sel_second && rx_data_i == s.pau2) ||
				(sel_either && (rx_data_i == s.pau1 || rx_data_i == s.pau2)) ||
				(sel_seq && s.prev_pau1 && rx_data_i == s.pau2);
		end

		// Transmit flow codes; upper byte goes out first when dual
		unique case (next_s.enhanced_features[3:2])
			2'b00: begin
				next_s.res_code = 16'h0000;
				next_s.pau_code = 16'h0000;
				next_s.code_len = 2'h0;
			end
			2'b10: begin
				next_s.res_code = {8'h00, next_s.res1};
				next_s.pau_code = {8'h00, next_s.pau1};
				next_s.code_len = 2'h1;
			end
			2'b01: begin
				next_s.res_code = {8'h00, next_s.res2};
				next_s.pau_code = {8'h00, next_s.pau2};
				next_s.code_len = 2'h1;
			end
			2'b11: begin
				next_s.res_code = {next_s.res1, next_s.res2};
				next_s.pau_code = {next_s.pau1, next_s.pau2};
				next_s.code_len = 2'h2;
			end
		endcase

		// Sampling select; bit 5 overrides bit 4
		if (next_s.frac[5]) begin
			next_s.samp = ushfc_pkg::SAMP_4X;
		end else if (next_s.frac[4]) begin
			next_s.samp = ushfc_pkg::SAMP_8X;
		end else begin
			next_s.samp = ushfc_pkg::SAMP_16X;
		end

		// Hand the head to the shifter unless auto flow holds it off
		next_s.tx_valid = (next_s.tx_cnt != '0) &&
			!(next_s.enhanced_features[ushfc_pkg::EF_ACTS] && s.pin_s2[0]);
		next_s.tx_data = next_s.tx_mem[next_s.tx_rp];

		// Interrupt requests from next state so they track flags
		next_s.line_irq = next_s.interrupt_enables[ushfc_pkg::IE_LINE] &&
			(next_s.overrun || (next_s.rx_cnt != '0 &&
			(next_s.rx_mem[next_s.rx_rp][ushfc_pkg::TAG_PE] ||
			next_s.rx_mem[next_s.rx_rp][ushfc_pkg::TAG_FE] ||
			next_s.rx_mem[next_s.rx_rp][ushfc_pkg::TAG_BI])));
		next_s.modem_irq = next_s.interrupt_enables[ushfc_pkg::IE_MODEM] &&
			(next_s.delta != 4'h0);
	end

	// State register; pins idle high so synchronisers reset to one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.rx_s1 <= 1'b1;
			s.rx_s2 <= 1'b1;
			s.pin_s1 <= 4'hF;
			s.pin_s2 <= 4'hF;
			s.scratch <= ushfc_pkg::RST_SCRATCH;
			s.dll <= ushfc_pkg::RST_DIV_LOW;
			s.divisor_high_byte <= ushfc_pkg::RST_ZERO;
			s.frac <= ushfc_pkg::RST_ZERO;
			s.enhanced_features <= ushfc_pkg::RST_ZERO;
		end else begin
			s <= next_s;
		end
	end

	// Outputs taken straight from state flops
	assign rdata_o = s.rdata;
	assign tx_valid_o = s.tx_valid;
	assign tx_data_o = s.tx_data;
	assign line_irq_o = s.line_irq;
	assign modem_irq_o = s.modem_irq;
	assign baud_divisor_o = {s.divisor_high_byte, s.dll};
	assign baud_fraction_o = s.frac[3:0];
	assign sample_rate_o = s.samp;
	assign modem_control_o = s.modem_control;
	assign tx_resume_code_o = s.res_code;
	assign tx_pause_code_o = s.pau_code;
	assign tx_code_len_o = s.code_len;
	assign resume_seen_o = s.res_seen;
	assign pause_seen_o = s.pau_seen;
endmodule

// >>> tb/ushfc_checker.sv
// Concurrent checks on the register block ports
`timescale 1ns/10ps
module ushfc_checker (
	// Clock, reset, register port and receiver event
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	input wire logic rx_done_i,
	// Observed outputs
	input wire logic line_irq_o,
	input wire logic modem_irq_o,
	input wire logic [15:0] baud_divisor_o,
	input wire logic [3:0] baud_fraction_o,
	input wire logic [1:0] sample_rate_o,
	input wire logic [7:0] modem_control_o,
	input wire logic [15:0] tx_resume_code_o,
	input wire logic [1:0] tx_code_len_o,
	input wire logic resume_seen_o,
	input wire logic pause_seen_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic frac_wr;
	// Fraction output may trail its write by one extra stage
	assign frac_wr = we_i && addr_i == ushfc_pkg::ADDR_FRACTION;
	div_low_a: assert property (
		we_i && addr_i == ushfc_pkg::ADDR_DIV_LOW
		|=> baud_divisor_o[7:0] == $past(wdata_i))
		else $error("divisor low byte not taken");
	mctrl_write_a: assert property (
		we_i && addr_i == ushfc_pkg::ADDR_MODEM_CTRL
		|=> modem_control_o[4:0] == $past(wdata_i[4:0]))
		else $error("modem control write lost");
	frac_guard_a: assert property (
		$changed(baud_fraction_o) |-> $past(frac_wr) || $past(frac_wr, 2))
		else $error("fraction changed without a write");
	samp_code_a: assert property (sample_rate_o != 2'h3)
		else $error("illegal sampling code");
	code_len_a: assert property (tx_code_len_o != 2'h3)
		else $error("illegal flow code length");
	code_change_a: assert property (
		$changed(tx_resume_code_o) |-> $past(we_i) || $past(we_i, 2))
		else $error("resume code changed without a write");
	modem_clear_a: assert property (
		$fell(modem_irq_o) |-> $past(we_i || re_i))
		else $error("modem interrupt dropped by itself");
	line_cause_a: assert property (
		$rose(line_irq_o) |-> $past(rx_done_i || we_i || re_i))
		else $error("line interrupt without cause");
	seen_cause_a: assert property (
		resume_seen_o || pause_seen_o |-> $past(rx_done_i))
		else $error("flow match without a character");
	cover property ($rose(modem_irq_o));
	cover property (resume_seen_o);
	cover property (pause_seen_o);
endmodule

// >>> tb/ushfc_line_model.sv
// Far-side model: modem pins, receiver events and the transmit shifter
`timescale 1ns/10ps
module ushfc_line_model (
	// Clock
	input wire logic clk_i,
	// Transmit handshake
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o,
	output logic tx_busy_o,
	// Receiver events and pins
	output logic rx_done_o,
	output logic [7:0] rx_data_o,
	output logic [2:0] rx_err_o,
	output logic rx_line_o,
	output logic [3:0] pins_n_o
);
	int hold = 2;
	int cnt = 0;
	logic [7:0] last_tx = 8'h00;
	// Idle line, all modem pins inactive high
	initial begin
		rx_done_o = 1'b0;
		rx_data_o = 8'h00;
		rx_err_o = 3'h0;
		rx_line_o = 1'b1;
		pins_n_o = 4'hF;
	end
	// Shifter ignores the pins: a started character always completes
	assign tx_ready_o = (cnt == 0);
	assign tx_busy_o = (cnt != 0);
	// Take one character, then stay busy for hold cycles
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			last_tx <= tx_data_i;
			cnt <= hold;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
	end
	// One character event; tags are {break, framing, parity}
	task send(input logic [7:0] d, input logic [2:0] e);
		@(posedge clk_i);
		rx_done_o <= 1'b1;
		rx_data_o <= d;
		rx_err_o <= e;
		@(posedge clk_i);
		rx_done_o <= 1'b0;
		rx_data_o <= ~d; // Stale qualifiers must not look valid
		rx_err_o <= ~e;
	endtask
endmodule

// >>> tb/ushfc_regs_bench.sv
// Self-checking bench for the channel register block
`timescale 1ns/10ps
module ushfc_regs_bench;
	logic clk_i, rst_i, we_i, re_i, rx_done_i, rx_line_i;
	logic tx_ready_i, tx_busy_i, tx_valid_o, line_irq_o, modem_irq_o;
	logic resume_seen_o, pause_seen_o;
	logic [3:0] addr_i, pins_n, baud_fraction_o;
	logic [7:0] wdata_i, rdata_o, tx_data_o, rx_data_i, modem_control_o, r;
	logic [2:0] rx_err;
	logic [15:0] baud_divisor_o, tx_resume_code_o, tx_pause_code_o;
	logic [1:0] sample_rate_o, tx_code_len_o;
	logic [7:0] ch [4];
	logic [9:0] q [64];
	int n_mismatch = 0;
	int n_checks = 0;
	int seed = 32'h92af;
	int i;
	int nerr;
	ushfc_regs #(.DEPTH(64)) ushfc_regs_i (.clk_i(clk_i), .rst_i(rst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
		.rdata_o(rdata_o), .rx_done_i(rx_done_i), .rx_data_i(rx_data_i),
		.rx_parity_err_i(rx_err[0]), .rx_frame_err_i(rx_err[1]),
		.rx_break_i(rx_err[2]), .rx_line_i(rx_line_i), .cts_n_i(pins_n[0]),
		.dsr_n_i(pins_n[1]), .ring_in_n_i(pins_n[2]),
		.carrier_in_n_i(pins_n[3]), .tx_ready_i(tx_ready_i),
		.tx_busy_i(tx_busy_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
		.line_irq_o(line_irq_o), .modem_irq_o(modem_irq_o),
		.baud_divisor_o(baud_divisor_o), .baud_fraction_o(baud_fraction_o),
		.sample_rate_o(sample_rate_o), .modem_control_o(modem_control_o),
		.tx_resume_code_o(tx_resume_code_o), .tx_pause_code_o(tx_pause_code_o),
		.tx_code_len_o(tx_code_len_o), .resume_seen_o(resume_seen_o),
		.pause_seen_o(pause_seen_o));
	ushfc_line_model m_i (.clk_i(clk_i), .tx_valid_i(tx_valid_o),
		.tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i), .tx_busy_o(tx_busy_i),
		.rx_done_o(rx_done_i), .rx_data_o(rx_data_i), .rx_err_o(rx_err),
		.rx_line_o(rx_line_i), .pins_n_o(pins_n));
	// Expected sampling code and flow-code length
	function automatic logic [1:0] samp(input logic [7:0] d);
		return d[5] ? 2'h2 : {1'b0, d[4]};
	endfunction
	function automatic logic [1:0] clen(input logic [1:0] t);
		return (t == 2'h3) ? 2'h2 : {1'b0, ^t};
	endfunction
	// Upper bit of t picks the first pair; both bits give a sequence
	function automatic logic [15:0] pick(input logic [1:0] t,
		input logic [7:0] a, input logic [7:0] b);
		if (t == 2'h0) begin
			return 16'h0000;
		end
		return (t == 2'h3) ? {a, b} : {8'h00, t[1] ? a : b};
	endfunction
	task chk(input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task give_verdict();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// One-cycle strobes; results are looked at just after the edge
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'b1;
		@(posedge clk_i);
		we_i <= 1'b0;
		#1;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_i);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask
	// Choose a flow mode after clearing it, send one character
	task flow(input logic [7:0] e, input logic [7:0] c, input logic [1:0] p);
		wr(4'h7, 8'h10);
		wr(4'h7, e);
		m_i.send(c, 3'h0);
		#1 chk({pause_seen_o, resume_seen_o}, p);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// A hang is cut short well past the expected run length
	initial begin
		#100000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		rst_i = 1'b1;
		we_i = 1'b0;
		re_i = 1'b0;
		addr_i = 4'h0;
		wdata_i = 8'h00;
		tick(8);
		rst_i <= 1'b0;
		rd(4'h1, 8'h60);
		rd(4'h3, 8'hFF);
		rd(4'h4, 8'h01);
		rd(4'h2, 8'h00);
		for (i = 0; i < 4; i++) begin
			r = 8'($random(seed));
			ch[i] = 8'($random(seed));
			wr(4'h3, r);
			rd(4'h3, r);
			wr(4'h4, r);
			wr(4'h5, ch[i]);
			chk(baud_divisor_o, {ch[i], r});
			wr(4'(11 + i), ch[i]);
		end
		wr(4'h6, 8'h3A);
		rd(4'h6, 8'h00);
		wr(4'h7, 8'h10);
		for (i = 0; i < 4; i++) begin
			r = {2'h0, 2'(i), 4'(i + 5)};
			wr(4'h6, r);
			rd(4'h6, r);
			chk(sample_rate_o, samp(r));
			chk(baud_fraction_o, r[3:0]);
		end
		// Upper modem-control bits only move while enhanced enable is on
		wr(4'h8, 8'hE0);
		chk(modem_control_o, 8'hE0);
		wr(4'h7, 8'h00);
		wr(4'h6, 8'h05);
		chk(baud_fraction_o, r[3:0]);
		wr(4'h8, 8'h00);
		chk(modem_control_o, 8'hE0);
		for (i = 0; i < 4; i++) begin
			wr(4'h7, 8'h10);
			wr(4'h7, 8'h10 | 8'(i << 2));
			tick(2);
			chk(tx_code_len_o, clen(2'(i)));
			chk(tx_resume_code_o, pick(2'(i), ch[0], ch[1]));
			chk(tx_pause_code_o, pick(2'(i), ch[2], ch[3]));
		end
		flow(8'h12, ch[0], 2'h1);
		flow(8'h11, ch[0], 2'h0);
		flow(8'h11, ch[1], 2'h1);
		flow(8'h1B, ch[3], 2'h2);
		flow(8'h13, ch[2], 2'h0);
		m_i.send(ch[3], 3'h0);
		#1 chk({pause_seen_o, resume_seen_o}, 2'h2);
		rst_i <= 1'b1;
		tick(3);
		rst_i <= 1'b0;
		wr(4'h9, 8'h0C);
		m_i.send(ch[0], 3'h1);
		#1 chk(line_irq_o, 1'b1);
		rd(4'h1, 8'hE5);
		rd(4'h0, ch[0]);
		rd(4'h1, 8'h60);
		chk(line_irq_o, 1'b0);
		m_i.send(ch[1], 3'h2);
		rd(4'h1, 8'hE9);
		rd(4'h0, ch[1]);
		m_i.send(ch[2], 3'h0);
		m_i.send(ch[3], 3'h0);
		#1 chk(line_irq_o, 1'b1);
		rd(4'h1, 8'h63);
		rd(4'h1, 8'h61);
		rd(4'h0, ch[2]);
		m_i.rx_line_o <= 1'b0;
		tick(3);
		m_i.send(8'h00, 3'h4);
		m_i.send(8'h00, 3'h4);
		rd(4'h1, 8'hF1);
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h70);
		m_i.rx_line_o <= 1'b1;
		tick(4);
		rd(4'h1, 8'h60);
		m_i.pins_n_o <= 4'hE;
		tick(5);
		chk(modem_irq_o, 1'b1);
		rd(4'h2, 8'h11);
		chk(modem_irq_o, 1'b0);
		rd(4'h2, 8'h10);
		m_i.pins_n_o <= 4'hA;
		tick(5);
		rd(4'h2, 8'h50);
		m_i.pins_n_o <= 4'h4;
		tick(5);
		rd(4'h2, 8'hBE);
		wr(4'h8, 8'h1F);
		chk(modem_control_o, 8'h1F);
		tick(4);
		rd(4'h2, 8'hF0);
		wr(4'h8, 8'h00);
		m_i.hold = 20;
		wr(4'h0, ch[0]);
		tick(3);
		rd(4'h1, 8'h20);
		tick(20);
		rd(4'h1, 8'h60);
		chk(m_i.last_tx, ch[0]);
		wr(4'h7, 8'h90);
		m_i.pins_n_o <= 4'h5;
		tick(5);
		wr(4'h0, ch[1]);
		tick(5);
		chk(tx_valid_o, 1'b0);
		rd(4'h1, 8'h00);
		m_i.pins_n_o <= 4'h4;
		tick(30);
		chk(m_i.last_tx, ch[1]);
		// FIFO mode: fill every entry, one more overruns, drain in order
		wr(4'hA, 8'h01);
		nerr = 0;
		for (i = 0; i < 64; i++) begin
			q[i] = 10'($random(seed));
			nerr += int'(q[i][9:8] != 2'h0);
			m_i.send(q[i][7:0], {1'b0, q[i][9:8]});
		end
		m_i.send(8'h5A, 3'h0);
		#1 chk(line_irq_o, 1'b1);
		for (i = 0; i < 64; i++) begin
			r = {nerr != 0, 2'h3, 1'b0, q[i][9:8], i == 0, 1'b1};
			rd(4'h1, r);
			rd(4'h0, q[i][7:0]);
			nerr -= int'(q[i][9:8] != 2'h0);
		end
		rd(4'h1, 8'h60);
		give_verdict();
	end
endmodule
bind ushfc_regs ushfc_checker ushfc_checker_i (.clk_i(clk_i), .rst_i(rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
	.rx_done_i(rx_done_i), .line_irq_o(line_irq_o),
	.modem_irq_o(modem_irq_o), .baud_divisor_o(baud_divisor_o),
	.baud_fraction_o(baud_fraction_o), .sample_rate_o(sample_rate_o),
	.modem_control_o(modem_control_o), .tx_resume_code_o(tx_resume_code_o),
	.tx_code_len_o(tx_code_len_o), .resume_seen_o(resume_seen_o),
	.pause_seen_o(pause_seen_o));
